// [hdl/port_group_pkg.sv]
// constants shared by the port group and its testbench
package port_group_pkg;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_INPUT_ONLY_PIN_LEVELS = 8'h03;
	localparam logic [7:0] OFS_EIGHT_PIN_PORT_LATCHES = 8'h08;
	localparam logic [7:0] OFS_SIX_PIN_PORT_LATCHES = 8'h09;
	localparam logic [7:0] OFS_SIX_PIN_PORT_DIRECTION = 8'h0d;
	localparam logic [7:0] OFS_EIGHT_PIN_PORT_DIRECTION = 8'h0c;
	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int IN_PINS = 7;
	localparam int E_PINS = 8;
	localparam int F_PINS = 6;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] E_TIMER_PIN_MASK = 8'h1f;
	localparam logic [7:0] E_SERIAL_PIN_MASK = 8'h60;
	localparam int SYNC_STAGES = 2;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// [hdl/pin_sync.sv]
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	// first stage read only by the second
	always_ff @(posedge clk_i) begin
		meta_reg <= async_i;
		sync_o <= meta_reg;
	end
endmodule

// [hdl/input_and_bidir_port_group.sv]
// input-only port plus two bidirectional ports behind a classic wishbone slave
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// - input port reads seven synchronised pin levels
// - input-pin latch write leaves pin level alone
// - reset leaves input port contents untouched
// - eight-pin port latches, timer/serial pins shared
// - eight-pin direction one drives, zero floats
// - reset clears eight-pin direction bits
// - eight-pin read: latch if output, else pin
// - bidirectional latches always accept writes
// - timer-owned pin ignores direction for drive
// - six-pin latches bits 5:0, reset keeps
// - six-pin direction drives; bits 7:6 zero
// - reset clears six-pin direction bits
// - six-pin read: latch if output, else pin
// - serial-owned six-pin pin ignores direction for drive
module input_and_bidir_port_group (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// input-only pins
	input wire logic [port_group_pkg::IN_PINS-1:0] in_pin_i,
	// eight-pin port
	input wire logic [port_group_pkg::E_PINS-1:0] e_pin_i,
	output logic [port_group_pkg::E_PINS-1:0] e_pin_o,
	output logic [port_group_pkg::E_PINS-1:0] e_pin_oe_n_o,
	input wire logic [port_group_pkg::E_PINS-1:0] e_alt_own_i,
	input wire logic [port_group_pkg::E_PINS-1:0] e_alt_out_i,
	input wire logic [port_group_pkg::E_PINS-1:0] e_alt_oe_i,
	// six-pin port
	input wire logic [port_group_pkg::F_PINS-1:0] f_pin_i,
	output logic [port_group_pkg::F_PINS-1:0] f_pin_o,
	output logic [port_group_pkg::F_PINS-1:0] f_pin_oe_n_o,
	input wire logic [port_group_pkg::F_PINS-1:0] f_alt_own_i,
	input wire logic [port_group_pkg::F_PINS-1:0] f_alt_out_i,
	input wire logic [port_group_pkg::F_PINS-1:0] f_alt_oe_i
);
	import port_group_pkg::*;

	logic [IN_PINS-1:0] in_sync;
	logic [E_PINS-1:0] e_sync;
	logic [F_PINS-1:0] f_sync;
	logic [E_PINS-1:0] e_latch_reg;
	logic [F_PINS-1:0] f_latch_reg;
	logic [E_PINS-1:0] e_dir_reg;
	logic [F_PINS-1:0] f_dir_reg;
	logic req;
	logic wr;
	logic [31:0] rd_next;

	// ****************************************
	// pin synchronisers
	// ****************************************
	pin_sync #(.WIDTH(IN_PINS)) u_in_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(in_pin_i),
		.sync_o(in_sync)
	);
	pin_sync #(.WIDTH(E_PINS)) u_e_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(e_pin_i),
		.sync_o(e_sync)
	);
	pin_sync #(.WIDTH(F_PINS)) u_f_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(f_pin_i),
		.sync_o(f_sync)
	);

	// per bit: latch when driven by software direction, pin otherwise
	function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
		mix_read = (dir & lat) | (~dir & pin);
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	// ack lasts one cycle; a held request gets a new ack every other cycle
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_comb begin
		rd_next = UNMAPPED_READ;
		case (wb_adr_i)
			OFS_INPUT_ONLY_PIN_LEVELS: rd_next = {25'h0, in_sync};
			OFS_EIGHT_PIN_PORT_LATCHES: rd_next = {24'h0, mix_read(e_dir_reg, e_latch_reg, e_sync)};
			OFS_SIX_PIN_PORT_LATCHES: rd_next = {24'h0, mix_read({2'h0, f_dir_reg}, {2'h0, f_latch_reg}, {2'h0, f_sync})};
			OFS_EIGHT_PIN_PORT_DIRECTION: rd_next = {24'h0, e_dir_reg};
			OFS_SIX_PIN_PORT_DIRECTION: rd_next = {26'h0, f_dir_reg};
			default: rd_next = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= UNMAPPED_READ;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= rd_next;
		end
	end

	// ****************************************
	// data latches, untouched by reset
	// ****************************************
	// the input-only port has no storage, so its writes vanish
	always_ff @(posedge clk_i) begin
		if (wr && wb_adr_i == OFS_EIGHT_PIN_PORT_LATCHES) begin
			e_latch_reg <= wb_dat_i[E_PINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr && wb_adr_i == OFS_SIX_PIN_PORT_LATCHES) begin
			f_latch_reg <= wb_dat_i[F_PINS-1:0];
		end
	end

	// ****************************************
	// direction registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e_dir_reg <= DIR_RESET[E_PINS-1:0];
		end else if (wr && wb_adr_i == OFS_EIGHT_PIN_PORT_DIRECTION) begin
			e_dir_reg <= wb_dat_i[E_PINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_dir_reg <= DIR_RESET[F_PINS-1:0];
		end else if (wr && wb_adr_i == OFS_SIX_PIN_PORT_DIRECTION) begin
			f_dir_reg <= wb_dat_i[F_PINS-1:0];
		end
	end

	// ****************************************
	// pin drivers, registered; enable low drives
	// ****************************************
	// one cycle of lag after a write; write the latch first to avoid a glitch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e_pin_o <= 8'h00;
		end else begin
			e_pin_o <= (e_alt_own_i & e_alt_out_i) | (~e_alt_own_i & e_latch_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e_pin_oe_n_o <= 8'hff;
		end else begin
			e_pin_oe_n_o <= ~((e_alt_own_i & e_alt_oe_i) | (~e_alt_own_i & e_dir_reg));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_pin_o <= 6'h00;
		end else begin
			f_pin_o <= (f_alt_own_i & f_alt_out_i) | (~f_alt_own_i & f_latch_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_pin_oe_n_o <= 6'h3f;
		end else begin
			f_pin_oe_n_o <= ~((f_alt_own_i & f_alt_oe_i) | (~f_alt_own_i & f_dir_reg));
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
	in_read_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_INPUT_ONLY_PIN_LEVELS) |=> wb_dat_o == {25'h0, $past(in_sync)})
		else $error("input port read wrong");
	in_bit7_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_INPUT_ONLY_PIN_LEVELS) |=> wb_dat_o[7] == 1'b0)
		else $error("input port bit 7 set");
	e_dir_reset_a: assert property (@(posedge clk_i)
		rst_i |=> e_dir_reg == 8'h00) else $error("eight-pin direction not cleared");
	f_dir_reset_a: assert property (@(posedge clk_i)
		rst_i |=> f_dir_reg == 6'h00) else $error("six-pin direction not cleared");
	e_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!e_alt_own_i[0]) |=> e_pin_oe_n_o[0] == !$past(e_dir_reg[0])) else $error("eight-pin drive wrong");
	e_timer_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(e_alt_own_i[0]) |=> e_pin_oe_n_o[0] == !$past(e_alt_oe_i[0])) else $error("timer drive wrong");
	f_serial_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(f_alt_own_i[0]) |=> f_pin_oe_n_o[0] == !$past(f_alt_oe_i[0])) else $error("serial drive wrong");
	e_latch_write_a: assert property (@(posedge clk_i)
		(wr && wb_adr_i == OFS_EIGHT_PIN_PORT_LATCHES) |=> e_latch_reg == $past(wb_dat_i[7:0]))
		else $error("latch write lost");
	f_read_mix_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_SIX_PIN_PORT_LATCHES) |=>
		wb_dat_o[5:0] == (($past(f_dir_reg) & $past(f_latch_reg)) | (~$past(f_dir_reg) & $past(f_sync))))
		else $error("six-pin read wrong");
	f_dir_high_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_SIX_PIN_PORT_DIRECTION) |=> wb_dat_o[7:6] == 2'h0)
		else $error("reserved bits set");

	// ****************************************
	// register and pin assertions
	// ****************************************
	e_read_mix_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_EIGHT_PIN_PORT_LATCHES)
		|=> wb_dat_o[7:0] == (($past(e_dir_reg) & $past(e_latch_reg)) | (~$past(e_dir_reg) & $past(e_sync))))
		else $error("eight-pin read wrong");
	e_pin_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
		e_alt_own_i[7]
		|=> e_pin_o[7] == $past(e_alt_out_i[7]))
		else $error("timer value not passed");
	f_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!f_alt_own_i[1]
		|=> f_pin_oe_n_o[1] == !$past(f_dir_reg[1]))
		else $error("six-pin drive wrong");
	f_pin_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
		f_alt_own_i[0]
		|=> f_pin_o[0] == $past(f_alt_out_i[0]))
		else $error("serial value not passed");
	unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i > OFS_SIX_PIN_PORT_DIRECTION)
		|=> wb_dat_o == UNMAPPED_READ)
		else $error("unmapped read not zero");
	in_write_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_INPUT_ONLY_PIN_LEVELS)
		|=> $stable(e_dir_reg) && $stable(f_dir_reg))
		else $error("input port write leaked");
	e_dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_EIGHT_PIN_PORT_DIRECTION)
		|=> e_dir_reg == $past(wb_dat_i[7:0]))
		else $error("eight-pin direction write lost");
	f_dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_SIX_PIN_PORT_DIRECTION)
		|=> f_dir_reg == $past(wb_dat_i[5:0]))
		else $error("six-pin direction write lost");
	f_latch_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_SIX_PIN_PORT_LATCHES)
		|=> f_latch_reg == $past(wb_dat_i[5:0]))
		else $error("six-pin latch write lost");
	reset_outputs_a: assert property (@(posedge clk_i)
		rst_i
		|=> !wb_ack_o && e_pin_oe_n_o == 8'hff && f_pin_oe_n_o == 6'h3f)
		else $error("outputs not idle after reset");
	read_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(req && !wb_we_i)
		|=> $stable(wb_dat_o))
		else $error("read data moved");
	e_dir_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_EIGHT_PIN_PORT_DIRECTION)
		|=> wb_dat_o == {24'h0, $past(e_dir_reg)})
		else $error("eight-pin direction read wrong");
	in_sync_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> in_sync == $past(in_pin_i, 2))
		else $error("input sync depth wrong");
	f_dir_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_SIX_PIN_PORT_DIRECTION)
		|=> wb_dat_o[5:0] == $past(f_dir_reg))
		else $error("six-pin direction read wrong");
	in_read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_INPUT_ONLY_PIN_LEVELS)
		|=> wb_dat_o[31:7] == 25'h0)
		else $error("input port upper bits set");

	// ****************************************
	// cover points
	// ****************************************
	cover_write_c: cover property (@(posedge clk_i) wr);
	cover_f_serial_c: cover property (@(posedge clk_i) f_alt_own_i[0] && f_dir_reg[0]);
	cover_unmapped_c: cover property (@(posedge clk_i) req && wb_adr_i > OFS_SIX_PIN_PORT_DIRECTION);
	cover_e_read_c: cover property (@(posedge clk_i) req && !wb_we_i && wb_adr_i == OFS_EIGHT_PIN_PORT_LATCHES);
	cover_timer_c: cover property (@(posedge clk_i) e_alt_own_i[0] && e_dir_reg[0]);
endmodule

// [tb/board_pins.sv]
// board model: resolves each port wire from device drive and board level
`timescale 1ns/1ps
module board_pins (
	// device side
	input wire logic [7:0] e_pin_o,
	input wire logic [7:0] e_pin_oe_n_o,
	input wire logic [5:0] f_pin_o,
	input wire logic [5:0] f_pin_oe_n_o,
	// board levels where the device floats the pin
	input wire logic [7:0] e_ext_i,
	input wire logic [5:0] f_ext_i,
	// resolved wires
	output logic [7:0] e_pin_i,
	output logic [5:0] f_pin_i
);
	// a driven pin shows the device value, a floating one the board level
	assign e_pin_i = (e_pin_o & ~e_pin_oe_n_o) | (e_ext_i & e_pin_oe_n_o);
	assign f_pin_i = (f_pin_o & ~f_pin_oe_n_o) | (f_ext_i & f_pin_oe_n_o);
endmodule

// [tb/tb_input_and_bidir_port_group.sv]
// self-checking bench for the port group
`timescale 1ns/1ps
module tb_input_and_bidir_port_group;
	import port_group_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0;
	logic [7:0] adr = 8'h00, e_ext = 8'h00, e_own = 8'h00, e_out = 8'h00, e_oe = 8'h00;
	logic [5:0] f_ext = 6'h00, f_own = 6'h00, f_out = 6'h00, f_oe = 6'h00;
	logic [31:0] wdat = 32'h0, dat_o, q;
	logic [6:0] in_pin = 7'h00;
	logic ack;
	logic [7:0] e_o, e_oe_n, e_i;
	logic [5:0] f_o, f_oe_n, f_i;
	int error_cnt = 0, n_compared = 0, cycles = 0;
	input_and_bidir_port_group u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.in_pin_i(in_pin), .e_pin_i(e_i), .e_pin_o(e_o), .e_pin_oe_n_o(e_oe_n), .e_alt_own_i(e_own),
		.e_alt_out_i(e_out), .e_alt_oe_i(e_oe), .f_pin_i(f_i), .f_pin_o(f_o), .f_pin_oe_n_o(f_oe_n),
		.f_alt_own_i(f_own), .f_alt_out_i(f_out), .f_alt_oe_i(f_oe));
	board_pins u_board (.e_pin_o(e_o), .e_pin_oe_n_o(e_oe_n), .f_pin_o(f_o), .f_pin_oe_n_o(f_oe_n),
		.e_ext_i(e_ext), .f_ext_i(f_ext), .e_pin_i(e_i), .f_pin_i(f_i));
	// ****************************************
	// bus and compare tasks
	// ****************************************
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) error_cnt++;
		q = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_i);
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic sc_reset_state();
		chk({24'h0, e_oe_n}, 32'hff);
		chk({26'h0, f_oe_n}, 32'h3f);
		rd(OFS_EIGHT_PIN_PORT_DIRECTION, 32'h00);
		rd(OFS_SIX_PIN_PORT_DIRECTION, 32'h00);
		rd(8'h1f, UNMAPPED_READ);
	endtask
	task automatic sc_input_port();
		in_pin <= 7'h55;
		settle();
		rd(OFS_INPUT_ONLY_PIN_LEVELS, 32'h55);
		wb(1'b1, OFS_INPUT_ONLY_PIN_LEVELS, 8'hff);
		rd(OFS_INPUT_ONLY_PIN_LEVELS, 32'h55);
		in_pin <= 7'h2a;
		settle();
		rd(OFS_INPUT_ONLY_PIN_LEVELS, 32'h2a);
	endtask
	task automatic sc_eight_port();
		e_ext <= 8'h3c;
		wb(1'b1, OFS_EIGHT_PIN_PORT_LATCHES, 8'ha5);
		settle();
		rd(OFS_EIGHT_PIN_PORT_LATCHES, 32'h3c);
		wb(1'b1, OFS_EIGHT_PIN_PORT_DIRECTION, 8'h0f);
		settle();
		rd(OFS_EIGHT_PIN_PORT_LATCHES, 32'h35);
		chk({24'h0, e_oe_n}, 32'hf0);
		chk({24'h0, e_o & 8'h0f}, 32'h05);
		// pin 0 timer-owned but idle, pin 7 timer-owned and driving high
		e_own <= 8'h81;
		e_oe <= 8'h80;
		e_out <= 8'h80;
		settle();
		chk({24'h0, e_oe_n}, 32'h71);
		rd(OFS_EIGHT_PIN_PORT_LATCHES, 32'hb5);
		e_own <= 8'h00;
	endtask
	task automatic sc_six_port();
		f_ext <= 6'h2a;
		wb(1'b1, OFS_SIX_PIN_PORT_LATCHES, 8'h15);
		wb(1'b1, OFS_SIX_PIN_PORT_DIRECTION, 8'hff);
		rd(OFS_SIX_PIN_PORT_DIRECTION, 32'h3f);
		rd(OFS_SIX_PIN_PORT_LATCHES, 32'h15);
		chk({26'h0, f_oe_n}, 32'h00);
		wb(1'b1, OFS_SIX_PIN_PORT_DIRECTION, 8'h07);
		settle();
		rd(OFS_SIX_PIN_PORT_LATCHES, 32'h2d);
		chk({26'h0, f_o}, 32'h15);
		f_own <= 6'h01;
		settle();
		chk({26'h0, f_oe_n}, 32'h39);
		rd(OFS_SIX_PIN_PORT_LATCHES, 32'h2d);
		f_own <= 6'h00;
	endtask
	task automatic sc_second_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFS_SIX_PIN_PORT_DIRECTION, 32'h00);
		rd(OFS_INPUT_ONLY_PIN_LEVELS, 32'h2a);
		chk({24'h0, e_oe_n}, 32'hff);
		wb(1'b1, OFS_SIX_PIN_PORT_DIRECTION, 8'h3f);
		rd(OFS_SIX_PIN_PORT_LATCHES, 32'h15);
		wb(1'b1, OFS_EIGHT_PIN_PORT_DIRECTION, 8'hff);
		rd(OFS_EIGHT_PIN_PORT_LATCHES, 32'ha5);
	endtask
	// a hang ends the run as a failure well after the expected hundred or so cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		sc_reset_state();
		sc_input_port();
		sc_eight_port();
		sc_six_port();
		sc_second_reset();
		complete_run();
	end
endmodule
